// [xs_pkg.sv]
// Package with the constants, types and register map of the exclusive-OR execution unit.
package xs_pkg;

    // Opcode fields of the 16-bit instruction word.
    localparam logic [7:0] XOR_LITERAL_OP          = 8'h0a;
    localparam logic [5:0] XOR_FILE_OP             = 6'h06;
    localparam logic [6:0] TEST_FILE_SKIP_ZERO_OP  = 7'h33;
    localparam int         OPC8_HI                 = 15;
    localparam int         OPC8_LO                 = 8;
    localparam int         OPC6_LO                 = 10;
    localparam int         OPC7_LO                 = 9;
    localparam int         DEST_BIT                = 9;
    localparam int         BANK_BIT                = 8;
    localparam int         OPERAND_HI              = 7;

    // Register byte addresses on the Avalon-MM slave.
    localparam int         ADDR_W                  = 5;
    localparam logic [4:0] REG_INSTR               = 5'h00;
    localparam logic [4:0] REG_WORKING             = 5'h04;
    localparam logic [4:0] REG_BANK_SELECT         = 5'h08;
    localparam logic [4:0] REG_STATUS              = 5'h0c;
    localparam logic [4:0] REG_FILE_ADDR           = 5'h10;
    localparam logic [4:0] REG_FILE_DATA           = 5'h14;
    localparam logic [4:0] REG_CYCLES              = 5'h18;

    // Field positions in the readable words.
    localparam int         TWO_WORD_BIT            = 16;
    localparam int         BUSY_BIT                = 8;
    localparam int         STAT_NEG                = 4;
    localparam int         STAT_ZERO               = 2;
    localparam int         BSR_W                   = 4;
    localparam int         FILE_ADDR_W             = 12;

    // Reset values and counts.
    localparam logic [7:0]  RESET_BYTE             = 8'h00;
    localparam logic [15:0] RESET_WORD16           = 16'h0000;
    localparam logic [31:0] RESET_WORD             = 32'h00000000;
    localparam logic [7:0]  ACCESS_SPLIT           = 8'h80;
    localparam logic [1:0]  IDLE_NONE              = 2'h0;
    localparam logic [1:0]  IDLE_ONE               = 2'h1;
    localparam logic [1:0]  IDLE_TWO               = 2'h2;

    typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} xs_phase_t;

    typedef struct packed {
        logic       isXorLiteral;
        logic       isXorFile;
        logic       isTestSkip;
        logic       toFile;
        logic       useBank;
        logic [7:0] operand;
    } xs_dec_t;

    typedef struct packed {
        logic [7:0] value;
        logic       negative;
        logic       zero;
    } xs_alu_t;

endpackage

// [xs_decoder.sv]
// Instruction decoder of the exclusive-OR execution unit.
`timescale 1ns/1ns
`default_nettype none
module xs_decoder (
    // Instruction word.
    input  wire logic [15:0]   instr,
    // Decoded fields.
    output xs_pkg::xs_dec_t    dec
);

    assign dec.isXorLiteral = instr[xs_pkg::OPC8_HI:xs_pkg::OPC8_LO] == xs_pkg::XOR_LITERAL_OP;
    assign dec.isXorFile    = instr[xs_pkg::OPC8_HI:xs_pkg::OPC6_LO] == xs_pkg::XOR_FILE_OP;
    assign dec.isTestSkip   = instr[xs_pkg::OPC8_HI:xs_pkg::OPC7_LO] == xs_pkg::TEST_FILE_SKIP_ZERO_OP;
    assign dec.toFile       = instr[xs_pkg::DEST_BIT];
    assign dec.useBank      = instr[xs_pkg::BANK_BIT];
    assign dec.operand      = instr[xs_pkg::OPERAND_HI:0];

endmodule
`default_nettype wire

// [xs_alu.sv]
// Exclusive-OR datapath with negative and zero flag generation.
`timescale 1ns/1ns
`default_nettype none
module xs_alu (
    // Operands.
    input  wire logic [7:0]    workingValue,
    input  wire logic [7:0]    operand,
    // Result and flags.
    output xs_pkg::xs_alu_t    res
);

    assign res.value    = workingValue ^ operand;
    assign res.negative = res.value[7];
    assign res.zero     = res.value == xs_pkg::RESET_BYTE;

endmodule
`default_nettype wire

// [xs_core.sv]
// Exclusive-OR and skip execution core with an Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
module xs_core #(
    parameter int NUM_BANKS = 2
) (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        resetn,
    // Avalon-MM slave.
    input  wire logic [xs_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    // Execution status.
    output logic                             busy
);

    localparam int BANK_W = $clog2(NUM_BANKS);
    localparam int IDX_W  = BANK_W + 8;
    localparam int DEPTH  = NUM_BANKS * 256;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // State.

    xs_pkg::xs_phase_t   phase;
    xs_pkg::xs_phase_t   next_phase;
    logic [15:0]         instr;
    logic                twoWordNext;
    xs_pkg::xs_dec_t     decLatched;
    logic [7:0]          operand;
    xs_pkg::xs_alu_t     result;
    logic                realCycle;
    logic                next_realCycle;
    logic [1:0]          idleLeft;
    logic [1:0]          next_idleLeft;
    logic [7:0]          workingRegister;
    logic [xs_pkg::BSR_W-1:0] bankSelectRegister;
    logic [7:0]          statusReg;
    logic [xs_pkg::FILE_ADDR_W-1:0] fileAddr;
    logic [15:0]         cycleCount;
    logic                ack;
    logic [7:0]          fileMem [DEPTH];

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Decode, datapath and addressing.

    xs_pkg::xs_dec_t     decNow;
    xs_pkg::xs_alu_t     aluOut;
    logic [IDX_W-1:0]    execIdx;
    logic [IDX_W-1:0]    busIdx;
    logic [7:0]          execFileValue;
    logic [7:0]          busFileValue;
    logic [1:0]          skipCount;
    logic [1:0]          q4Count;

    xs_decoder u_decoder (
        .instr (instr),
        .dec   (decNow)
    );

    xs_alu u_alu (
        .workingValue (workingRegister),
        .operand      (operand),
        .res          (aluOut)
    );

    assign execIdx = decLatched.useBank ? {bankSelectRegister[BANK_W-1:0], decLatched.operand}
                   : (decLatched.operand < xs_pkg::ACCESS_SPLIT) ? {BANK_W'(0), decLatched.operand}
                   : {BANK_W'(NUM_BANKS - 1), decLatched.operand};
    assign busIdx        = fileAddr[IDX_W-1:0];
    assign execFileValue = fileMem[execIdx];
    assign busFileValue  = fileMem[busIdx];

    assign skipCount = (decLatched.isTestSkip && operand == xs_pkg::RESET_BYTE)
                     ? (twoWordNext ? xs_pkg::IDLE_TWO : xs_pkg::IDLE_ONE) : xs_pkg::IDLE_NONE;
    assign q4Count   = realCycle ? skipCount : idleLeft - xs_pkg::IDLE_ONE;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic                accept;
    logic                wrDone;
    logic [31:0]         beMask;
    logic [31:0]         readMux;
    logic                selInstr;
    logic                selWorking;
    logic                selBank;
    logic                selStatus;
    logic                selFileAddr;
    logic                selFileData;
    logic                selCycles;
    logic                startExec;

    // Stalling the bus while an instruction runs keeps software and the datapath off the same registers.
    assign accept      = (avs_read | avs_write) & ~ack & ~busy;
    assign wrDone      = ack & avs_write;
    assign beMask      = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign selInstr    = avs_address == xs_pkg::REG_INSTR;
    assign selWorking  = avs_address == xs_pkg::REG_WORKING;
    assign selBank     = avs_address == xs_pkg::REG_BANK_SELECT;
    assign selStatus   = avs_address == xs_pkg::REG_STATUS;
    assign selFileAddr = avs_address == xs_pkg::REG_FILE_ADDR;
    assign selFileData = avs_address == xs_pkg::REG_FILE_DATA;
    assign selCycles   = avs_address == xs_pkg::REG_CYCLES;
    assign startExec   = wrDone & selInstr;
    assign readMux = selInstr    ? {15'h0000, twoWordNext, instr}
                   : selWorking  ? {24'h000000, workingRegister}
                   : selBank     ? {28'h0000000, bankSelectRegister}
                   : selStatus   ? {23'h000000, busy, statusReg}
                   : selFileAddr ? {20'h00000, fileAddr}
                   : selFileData ? {24'h000000, busFileValue}
                   : selCycles   ? {16'h0000, cycleCount}
                   : xs_pkg::RESET_WORD;

    logic [31:0]         mergedWord;
    logic [31:0]         oldWord;
    assign oldWord    = selInstr ? {15'h0000, twoWordNext, instr} : readMux;
    assign mergedWord = (oldWord & ~beMask) | (avs_writedata & beMask);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Execution write-back.

    logic                execQ4;
    logic                xorDone;
    logic                wrWorkingExec;
    logic                wrFileExec;
    logic                memWe;
    logic [IDX_W-1:0]    memIdx;
    logic [7:0]          memData;
    logic [7:0]          next_status;

    assign execQ4        = phase == xs_pkg::PH_Q4 && realCycle;
    assign xorDone       = execQ4 && (decLatched.isXorLiteral || decLatched.isXorFile);
    assign wrWorkingExec = execQ4 && (decLatched.isXorLiteral || (decLatched.isXorFile && !decLatched.toFile));
    assign wrFileExec    = execQ4 && decLatched.isXorFile && decLatched.toFile;
    assign memWe         = wrFileExec | (wrDone & selFileData);
    assign memIdx        = wrFileExec ? execIdx : busIdx;
    assign memData       = wrFileExec ? result.value : mergedWord[7:0];

    always_comb begin
        next_status = statusReg;
        if (wrDone && selStatus) begin
            next_status = mergedWord[7:0];
        end
        if (xorDone) begin
            next_status[xs_pkg::STAT_NEG]  = result.negative;
            next_status[xs_pkg::STAT_ZERO] = result.zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Phase sequencer.

    always_comb begin
        next_phase     = phase;
        next_idleLeft  = idleLeft;
        next_realCycle = realCycle;
        unique case (phase)
            xs_pkg::PH_IDLE: begin
                if (startExec) begin
                    next_phase     = xs_pkg::PH_Q1;
                    next_realCycle = 1'b1;
                end
            end
            xs_pkg::PH_Q1: next_phase = xs_pkg::PH_Q2;
            xs_pkg::PH_Q2: next_phase = xs_pkg::PH_Q3;
            xs_pkg::PH_Q3: next_phase = xs_pkg::PH_Q4;
            xs_pkg::PH_Q4: begin
                next_realCycle = 1'b0;
                next_idleLeft  = q4Count;
                next_phase     = (q4Count != xs_pkg::IDLE_NONE) ? xs_pkg::PH_Q1 : xs_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase     <= xs_pkg::PH_IDLE;
            idleLeft  <= xs_pkg::IDLE_NONE;
            realCycle <= 1'b0;
            busy      <= 1'b0;
        end else begin
            phase     <= next_phase;
            idleLeft  <= next_idleLeft;
            realCycle <= next_realCycle;
            busy      <= next_phase != xs_pkg::PH_IDLE;
        end
    end

    // Decode in Q1, operand read in Q2, processing in Q3.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            decLatched <= '0;
            operand    <= xs_pkg::RESET_BYTE;
            result     <= '0;
        end else if (realCycle) begin
            if (phase == xs_pkg::PH_Q1) begin
                decLatched <= decNow;
            end
            if (phase == xs_pkg::PH_Q2) begin
                operand <= decLatched.isXorLiteral ? decLatched.operand : execFileValue;
            end
            if (phase == xs_pkg::PH_Q3) begin
                result <= aluOut;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            instr              <= xs_pkg::RESET_WORD16;
            twoWordNext        <= 1'b0;
            workingRegister    <= xs_pkg::RESET_BYTE;
            bankSelectRegister <= '0;
            statusReg          <= xs_pkg::RESET_BYTE;
            fileAddr           <= '0;
        end else begin
            if (startExec) begin
                instr       <= mergedWord[15:0];
                twoWordNext <= mergedWord[xs_pkg::TWO_WORD_BIT];
            end
            if (wrWorkingExec) begin
                workingRegister <= result.value;
            end else if (wrDone && selWorking) begin
                workingRegister <= mergedWord[7:0];
            end
            if (wrDone && selBank) begin
                bankSelectRegister <= mergedWord[xs_pkg::BSR_W-1:0];
            end
            if (wrDone && selFileAddr) begin
                fileAddr <= mergedWord[xs_pkg::FILE_ADDR_W-1:0];
            end
            statusReg <= next_status;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cycleCount <= xs_pkg::RESET_WORD16;
        end else if (phase == xs_pkg::PH_Q4) begin
            cycleCount <= cycleCount + 16'h0001;
        end
    end

    // One flip-flop set per byte of the file register space.
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_mem
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    fileMem[gi] <= xs_pkg::RESET_BYTE;
                end else if (memWe && memIdx == IDX_W'(gi)) begin
                    fileMem[gi] <= memData;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Bus answer, one wait state per access while busy is low, longer while an instruction runs.

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack             <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= xs_pkg::RESET_WORD;
        end else begin
            ack             <= accept;
            avs_waitrequest <= ~accept;
            if (accept) begin
                avs_readdata <= readMux;
            end
        end
    end

endmodule
`default_nettype wire

// [xs_core_sva.sv]
// Concurrent checks on the ports of the exclusive-OR execution core.
`timescale 1ns/1ns
`default_nettype none
module xs_core_sva #(
    parameter int NUM_BANKS = 2
) (
    // Clock and reset.
    input wire logic                      clk,
    input wire logic                      resetn,
    // Avalon-MM slave.
    input wire logic [xs_pkg::ADDR_W-1:0] avs_address,
    input wire logic                      avs_read,
    input wire logic                      avs_write,
    input wire logic [31:0]               avs_writedata,
    input wire logic [3:0]                avs_byteenable,
    input wire logic [31:0]               avs_readdata,
    input wire logic                      avs_waitrequest,
    // Execution status.
    input wire logic                      busy
);
    wire logic       wrDone;
    wire logic       rdDone;
    wire logic       instrWr;
    wire logic       isLit;
    wire logic       isFile;
    wire logic       isSkip;
    wire logic [7:0] litRes;
    logic      [7:0] workSh;
    logic            workKnown;
    logic      [7:0] statSh;
    logic            flagKnown;

    assign wrDone  = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign rdDone  = avs_read && !avs_waitrequest;
    assign instrWr = wrDone && avs_address == xs_pkg::REG_INSTR;
    assign isLit   = avs_writedata[15:8] == xs_pkg::XOR_LITERAL_OP;
    assign isFile  = avs_writedata[15:10] == xs_pkg::XOR_FILE_OP;
    assign isSkip  = avs_writedata[15:9] == xs_pkg::TEST_FILE_SKIP_ZERO_OP;
    assign litRes  = workSh ^ avs_writedata[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Shadows lose track after a file operation, whose operand lives inside, except the working shadow when the result goes to the file.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            workSh    <= 8'h00;
            workKnown <= 1'b1;
            statSh    <= 8'h00;
            flagKnown <= 1'b1;
        end else if (wrDone) begin
            if (avs_address == xs_pkg::REG_WORKING) begin
                workSh    <= avs_writedata[7:0];
                workKnown <= 1'b1;
            end
            if (avs_address == xs_pkg::REG_STATUS) begin
                statSh    <= avs_writedata[7:0];
                flagKnown <= 1'b1;
            end
            if (instrWr && isLit) begin
                flagKnown                <= workKnown;
                workSh                   <= litRes;
                statSh[xs_pkg::STAT_NEG]  <= litRes[7];
                statSh[xs_pkg::STAT_ZERO] <= litRes == 8'h00;
            end
            if (instrWr && isFile) begin
                flagKnown <= 1'b0;
                workKnown <= workKnown && avs_writedata[xs_pkg::DEST_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_lit_time;
        instrWr && isLit |=> busy [*4] ##1 !busy;
    endproperty
    a_lit_time: assert property (p_lit_time)
        else $error("literal xor did not take one instruction cycle");
    property p_file_time;
        instrWr && isFile |=> busy [*4] ##1 !busy;
    endproperty
    a_file_time: assert property (p_file_time)
        else $error("file xor did not take one instruction cycle");
    property p_skip_one;
        instrWr && isSkip && !avs_writedata[16] |=> busy [*4] ##1 (!busy or (busy [*4] ##1 !busy));
    endproperty
    a_skip_one: assert property (p_skip_one)
        else $error("skip over one word took a wrong number of cycles");
    property p_skip_two;
        instrWr && isSkip && avs_writedata[16] |=> busy [*4] ##1 (!busy or (busy [*8] ##1 !busy));
    endproperty
    a_skip_two: assert property (p_skip_two)
        else $error("skip over two words took a wrong number of cycles");
    property p_work;
        rdDone && avs_address == xs_pkg::REG_WORKING && workKnown |-> avs_readdata == {24'h0, workSh};
    endproperty
    a_work: assert property (p_work)
        else $error("working register differs from expected xor result");
    property p_flags;
        rdDone && avs_address == xs_pkg::REG_STATUS && flagKnown
            |-> avs_readdata[4] == statSh[4] && avs_readdata[2] == statSh[2];
    endproperty
    a_flags: assert property (p_flags)
        else $error("negative or zero flag wrong");
    property p_other;
        rdDone && avs_address == xs_pkg::REG_STATUS
            |-> {avs_readdata[7:5], avs_readdata[3], avs_readdata[1:0]} == {statSh[7:5], statSh[3], statSh[1:0]};
    endproperty
    a_other: assert property (p_other)
        else $error("a status flag other than negative or zero changed");
    property p_hold;
        busy |-> avs_waitrequest;
    endproperty
    a_hold: assert property (p_hold)
        else $error("bus answered during execution");
endmodule
`default_nettype wire

// [xs_core_tb_top.sv]
// Self-checking testbench of the exclusive-OR execution core.
`timescale 1ns/1ns
`default_nettype none
module xs_core_tb_top;
    logic        clk;
    logic        resetn;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        busy;
    int          fail_count;
    int          samples_checked;
    logic [31:0] cyc;
    logic [31:0] base;
    logic [7:0]  lit [3] = '{8'haf, 8'h1a, 8'h80};
    logic [7:0]  wexp [3] = '{8'hb5 ^ 8'haf, 8'h00, 8'h80};
    logic [7:0]  sexp [3] = '{8'heb, 8'hef, 8'hfb};

    xs_core #(.NUM_BANKS(2)) DUT (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy));

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH time %0t got %h exp %h", $time, got, exp);
            fail_count++;
        end
    endtask

    // The request stands until waitrequest is seen low; a stuck slave ends the run.
    task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 200);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            results();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        access(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic exec(input logic [31:0] ins, output logic [31:0] n);
        wr(xs_pkg::REG_INSTR, ins);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy === 1'b1 && n < 100);
        if (busy !== 1'b0) begin
            fail_count++;
            results();
        end
        n = n - 1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk             = 1'b0;
        resetn          = 1'b0;
        avs_address     = 5'h00;
        avs_read        = 1'b0;
        avs_write       = 1'b0;
        avs_writedata   = 32'h0;
        avs_byteenable  = 4'hf;
        fail_count      = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rdchk(xs_pkg::REG_WORKING, 32'h0);
        rdchk(xs_pkg::REG_CYCLES, 32'h0);
        wr(5'h1c, 32'hffffffff);
        rdchk(5'h1c, 32'h0);
        wr(xs_pkg::REG_STATUS, 32'heb);
        wr(xs_pkg::REG_WORKING, 32'hb5);
        for (int i = 0; i < 3; i++) begin
            exec({16'h0, xs_pkg::XOR_LITERAL_OP, lit[i]}, cyc);
            chk(cyc, 32'h4);
            rdchk(xs_pkg::REG_WORKING, {24'h0, wexp[i]});
            rdchk(xs_pkg::REG_STATUS, {24'h0, sexp[i]});
        end
        wr(xs_pkg::REG_BANK_SELECT, 32'h1);
        wr(xs_pkg::REG_FILE_ADDR, 32'h120);
        wr(xs_pkg::REG_FILE_DATA, 32'haf);
        wr(xs_pkg::REG_FILE_ADDR, 32'h020);
        wr(xs_pkg::REG_FILE_DATA, 32'h0f);
        wr(xs_pkg::REG_FILE_ADDR, 32'h190);
        wr(xs_pkg::REG_FILE_DATA, 32'h33);
        wr(xs_pkg::REG_WORKING, 32'hb5);
        exec({16'h0, xs_pkg::XOR_FILE_OP, 1'b1, 1'b1, 8'h20}, cyc);
        chk(cyc, 32'h4);
        rdchk(xs_pkg::REG_WORKING, 32'hb5);
        wr(xs_pkg::REG_FILE_ADDR, 32'h120);
        rdchk(xs_pkg::REG_FILE_DATA, {24'h0, 8'haf ^ 8'hb5});
        rdchk(xs_pkg::REG_STATUS, 32'heb);
        exec({16'h0, xs_pkg::XOR_FILE_OP, 1'b0, 1'b0, 8'h20}, cyc);
        rdchk(xs_pkg::REG_WORKING, {24'h0, 8'hb5 ^ 8'h0f});
        wr(xs_pkg::REG_FILE_ADDR, 32'h020);
        rdchk(xs_pkg::REG_FILE_DATA, 32'h0f);
        rdchk(xs_pkg::REG_STATUS, 32'hfb);
        wr(xs_pkg::REG_BANK_SELECT, 32'h0);
        exec({16'h0, xs_pkg::XOR_FILE_OP, 1'b0, 1'b0, 8'h90}, cyc);
        rdchk(xs_pkg::REG_WORKING, {24'h0, 8'hba ^ 8'h33});
        avs_byteenable <= 4'he;
        wr(xs_pkg::REG_WORKING, 32'h000000ff);
        avs_byteenable <= 4'hf;
        rdchk(xs_pkg::REG_WORKING, {24'h0, 8'hba ^ 8'h33});
        access(1'b0, xs_pkg::REG_CYCLES, 32'h0, base);
        exec({15'h0, 1'b0, xs_pkg::TEST_FILE_SKIP_ZERO_OP, 1'b0, 8'h30}, cyc);
        chk(cyc, 32'h8);
        exec({15'h0, 1'b1, xs_pkg::TEST_FILE_SKIP_ZERO_OP, 1'b0, 8'h30}, cyc);
        chk(cyc, 32'hc);
        exec({15'h0, 1'b1, xs_pkg::TEST_FILE_SKIP_ZERO_OP, 1'b0, 8'h20}, cyc);
        chk(cyc, 32'h4);
        rdchk(xs_pkg::REG_CYCLES, base + 32'h6);
        rdchk(xs_pkg::REG_INSTR, 32'h00016620);
        results();
    end
endmodule

bind xs_core xs_core_sva #(.NUM_BANKS(NUM_BANKS)) u_sva (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy));
`default_nettype wire
